// >>> hw/ieb_map.svh
// register offsets, field masks, reset values for the enable bank
`ifndef IEB_MAP_SVH
`define IEB_MAP_SVH
`define IEB_OFF_EN_ONE     8'h00
`define IEB_OFF_EN_TWO     8'h04
`define IEB_OFF_EN_THREE   8'h08
`define IEB_OFF_FLAG_ONE   8'h0C
`define IEB_OFF_FLAG_TWO   8'h10
`define IEB_OFF_FLAG_THREE 8'h14
`define IEB_OFF_PRIO_BASE  8'h20
`define IEB_OFF_IRQ_STAT   8'h80
`define IEB_OFF_IRQ_MASK   8'h84
`define IEB_MASK_ONE       16'hFEDF
`define IEB_MASK_TWO       16'h3FE3
`define IEB_MASK_THREE     16'h4066
`define IEB_RST_EN         16'h0000
`define IEB_RST_PRIO       3'h4
`define IEB_PRIO_OFF       3'h0
`endif

// >>> hw/ieb_pkg.sv
// shared types for the interrupt enable bank
package ieb_pkg;
  typedef struct packed {
    logic [15:0] one;
    logic [15:0] two;
    logic [15:0] three;
  } ieb_bank_t;
  typedef enum logic [1:0] {
    IEB_R_IDLE = 2'b00,
    IEB_R_RESP = 2'b01
  } ieb_rd_state_t;
endpackage

// >>> hw/ieb_gate.sv
// one source path: flag, enable and priority gating
`timescale 1ns/1ns
`include "ieb_map.svh"
module ieb_gate
  import ieb_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // source side
  input  wire logic       src_pulse,
  input  wire logic       flag_clr,
  input  wire logic       flag_set_sw,
  // control
  input  wire logic       enable,
  input  wire logic [2:0] prio,
  // results
  output logic            flag_q,
  output logic            req
);
  logic flag_d;

  // flag records an occurred request; hardware set wins over clear
  always_comb
  begin
    flag_d = flag_q;
    if (flag_clr)
      flag_d = 1'b0;
    if (src_pulse || flag_set_sw)
      flag_d = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  // level zero priority disables regardless of enable
  assign req = flag_q && enable
            && (prio != `IEB_PRIO_OFF);
endmodule // ieb_gate

// >>> hw/ieb_top.sv
// interrupt enable bank with axi4-lite register access
//
// Notes on behaviour
// - set enable passes request, clear blocks it
// - first register upper byte, bit 8 absent
// - first register lower byte, bit 5 absent
// - second register upper byte, 15..14 absent
// - second register low bits, 4..2 absent
// - third register bit 14 calendar only high
// - third register low bits, 4..3,0 absent
// - unimplemented bits always read zero; priority fields of absent sources read the reset level 4 instead
// - reset clears every enable bit
// - flag records that a request occurred
// - three bit priority, zero disables source
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "ieb_map.svh"
module ieb_top
  import ieb_pkg::*;
#(
  parameter int NSRC = 48
)(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // axi4-lite write address
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [7:0]       s_axi_awaddr,
  // axi4-lite write data
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  // axi4-lite write response
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  // axi4-lite read address
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [7:0]       s_axi_araddr,
  // axi4-lite read data
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  // peripheral event pulses, bit order as the enable registers
  input  wire logic [NSRC-1:0]  src_event,
  // gated requests toward the priority logic
  output logic [NSRC-1:0]       irq_req_q,
  // summary interrupt
  output logic                  irq_q
);

  ////////////////////////////////////////////////////////////////////////
  // register state
  localparam logic [NSRC-1:0] IMPL =
    {`IEB_MASK_THREE, `IEB_MASK_TWO, `IEB_MASK_ONE};

  ieb_bank_t          en_q, en_d;
  logic [NSRC*3-1:0]  prio_q, prio_d;
  logic [1:0]         stat_q, stat_d;
  logic [1:0]         mask_q, mask_d;
  logic [NSRC-1:0]    flag_q, flag_clr, flag_set, req_w;
  logic [NSRC-1:0]    src_sync1_q, src_sync2_q, src_prev_q, src_pulse;

  // axi write channel capture
  logic               aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]         aw_addr_q, aw_addr_d;
  logic [31:0]        w_data_q, w_data_d;
  logic [3:0]         w_strb_q, w_strb_d;
  logic               bvalid_d;
  logic [1:0]         bresp_d;
  ieb_rd_state_t      rd_q, rd_d;
  logic [31:0]        rdata_d;
  logic [1:0]         rresp_d;
  logic               do_wr;
  logic [47:0]        en_flat;

  assign en_flat = {en_q.three, en_q.two, en_q.one};

  ////////////////////////////////////////////////////////////////////////
  // event inputs come from other logic pins, so two flops then edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_sync1_q <= '0;
      src_sync2_q <= '0;
      src_prev_q  <= '0;
    end
    else
    begin
      src_sync1_q <= src_event;
      src_sync2_q <= src_sync1_q;
      src_prev_q  <= src_sync2_q;
    end
  end
  assign src_pulse = src_sync2_q & ~src_prev_q & IMPL;

  // one gate per source; absent positions never set
  for (genvar i = 0; i < NSRC; i++)
  begin : g_src
    ieb_gate u_gate (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .src_pulse   (src_pulse[i]),
      .flag_clr    (flag_clr[i]),
      .flag_set_sw (flag_set[i]),
      .enable      (en_flat[i]),
      .prio        (prio_q[i*3 +: 3]),
      .flag_q      (flag_q[i]),
      .req         (req_w[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // axi write path: address and data in either order
  assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;

  always_comb
  begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (do_wr)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = 2'b00;
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_d = 1'b0;
  end

  // register updates on a completed write; low two lanes only matter
  always_comb
  begin : reg_next
    logic [15:0] wm;
    logic [15:0] wv;
    wm       = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wv       = w_data_q[15:0];
    en_d     = en_q;
    prio_d   = prio_q;
    mask_d   = mask_q;
    flag_clr = '0;
    flag_set = '0;
    stat_d   = stat_q;
    if (do_wr)
    begin
      case (aw_addr_q)
        `IEB_OFF_EN_ONE:
          en_d.one = (en_q.one & ~wm)
                   | (wv & wm & `IEB_MASK_ONE);
        `IEB_OFF_EN_TWO:
          en_d.two = (en_q.two & ~wm)
                   | (wv & wm & `IEB_MASK_TWO);
        `IEB_OFF_EN_THREE:
          en_d.three = (en_q.three & ~wm)
                     | (wv & wm & `IEB_MASK_THREE);
        `IEB_OFF_FLAG_ONE:
        begin
          flag_clr[15:0] = wm & ~wv;
          flag_set[15:0] = wm & wv & `IEB_MASK_ONE;
        end
        `IEB_OFF_FLAG_TWO:
        begin
          flag_clr[31:16] = wm & ~wv;
          flag_set[31:16] = wm & wv & `IEB_MASK_TWO;
        end
        `IEB_OFF_FLAG_THREE:
        begin
          flag_clr[47:32] = wm & ~wv;
          flag_set[47:32] = wm & wv & `IEB_MASK_THREE;
        end
        `IEB_OFF_IRQ_STAT:
          if (w_strb_q[0])
            stat_d = stat_q & ~wv[1:0];
        `IEB_OFF_IRQ_MASK:
          if (w_strb_q[0])
            mask_d = wv[1:0];
        default:
          for (int r = 0; r < 3; r++)
            if (aw_addr_q == `IEB_OFF_PRIO_BASE + 8'(r * 4))
              for (int k = 0; k < 5; k++)
                if (wm[k*3] && IMPL[r*16+k])
                  prio_d[(r*16+k)*3 +: 3] = wv[k*3 +: 3];
      endcase
    end
    // events: bit0 any source event pulse, bit1 any gated request rising; set wins
    if (|src_pulse)
      stat_d[0] = 1'b1;
    if (|(req_w & ~irq_req_q))
      stat_d[1] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // axi read path, one cycle to answer
  always_comb
  begin
    rd_d    = rd_q;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    case (rd_q)
      IEB_R_IDLE:
        if (s_axi_arvalid)
        begin
          rd_d    = IEB_R_RESP;
          rresp_d = 2'b00;
          rdata_d = 32'h0000_0000;
          case (s_axi_araddr)
            `IEB_OFF_EN_ONE:     rdata_d[15:0] = en_q.one & `IEB_MASK_ONE;
            `IEB_OFF_EN_TWO:     rdata_d[15:0] = en_q.two & `IEB_MASK_TWO;
            `IEB_OFF_EN_THREE:   rdata_d[15:0] = en_q.three & `IEB_MASK_THREE;
            `IEB_OFF_FLAG_ONE:   rdata_d[15:0] = flag_q[15:0];
            `IEB_OFF_FLAG_TWO:   rdata_d[15:0] = flag_q[31:16];
            `IEB_OFF_FLAG_THREE: rdata_d[15:0] = flag_q[47:32];
            `IEB_OFF_IRQ_STAT:   rdata_d[1:0]  = stat_q;
            `IEB_OFF_IRQ_MASK:   rdata_d[1:0]  = mask_q;
            `IEB_OFF_PRIO_BASE, 8'h24, 8'h28:
              for (int k = 0; k < 5; k++)
                rdata_d[k*3 +: 3] =
                  prio_q[(int'(s_axi_araddr[3:2])*16+k)*3 +: 3];
            default:             rresp_d = 2'b10;
          endcase
        end
      IEB_R_RESP:
        if (s_axi_rready)
          rd_d = IEB_R_IDLE;
      default:
        rd_d = IEB_R_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // all other registers; reset clears enables and sets default priority
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_q          <= '{`IEB_RST_EN, `IEB_RST_EN, `IEB_RST_EN};
      prio_q        <= {NSRC{`IEB_RST_PRIO}};
      stat_q        <= 2'h0;
      mask_q        <= 2'h0;
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_have_q      <= 1'b0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      rd_q          <= IEB_R_IDLE;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      irq_req_q     <= '0;
      irq_q         <= 1'b0;
    end
    else
    begin
      en_q          <= en_d;
      prio_q        <= prio_d;
      stat_q        <= stat_d;
      mask_q        <= mask_d;
      aw_have_q     <= aw_have_d;
      aw_addr_q     <= aw_addr_d;
      w_have_q      <= w_have_d;
      w_data_q      <= w_data_d;
      w_strb_q      <= w_strb_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      rd_q          <= rd_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
      s_axi_awready <= !aw_have_d; // free slot, registered
      s_axi_wready  <= !w_have_d;
      s_axi_arready <= (rd_d == IEB_R_IDLE);
      s_axi_rvalid  <= (rd_d == IEB_R_RESP);
      irq_req_q     <= req_w & IMPL;
      irq_q         <= |(stat_d & mask_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_en_off(i);
    !en_flat[i];
  endsequence

  AST_GATE_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    s_en_off(0) |=> !irq_req_q[0])
    else $error("request passed with enable clear");
  AST_GATE_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_q[0] && en_flat[0] && |prio_q[2:0]) |=> irq_req_q[0])
    else $error("request blocked while flag and enable set");
  AST_ONE_ABSENT: assert property (@(posedge aclk) disable iff (!aresetn)
    (en_q.one & ~`IEB_MASK_ONE) == 16'h0000)
    else $error("absent bit stored in first register");
  AST_ONE_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    !en_q.one[5] && !irq_req_q[5])
    else $error("bit 5 of first register active");
  AST_TWO_ABSENT: assert property (@(posedge aclk) disable iff (!aresetn)
    en_q.two[15:14] == 2'b00)
    else $error("absent high bits of second register set");
  AST_TWO_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    en_q.two[4:2] == 3'b000 && irq_req_q[20:18] == 3'b000)
    else $error("absent low bits of second register set");
  AST_THREE_HI: assert property (@(posedge aclk) disable iff (!aresetn)
    en_q.three[15] == 1'b0 && en_q.three[13:7] == 7'h00)
    else $error("absent high bits of third register set");
  AST_THREE_LO: assert property (@(posedge aclk) disable iff (!aresetn)
    en_q.three[4:3] == 2'b00 && !en_q.three[0])
    else $error("absent low bits of third register set");
  AST_RD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `IEB_OFF_EN_ONE)
    |=> s_axi_rvalid && !s_axi_rdata[5] && !s_axi_rdata[8])
    else $error("absent bit read as one");
  AST_RESET_CLR: assert property (@(posedge aclk)
    !aresetn |=> en_flat == 48'h0)
    else $error("enable not cleared by reset");
  AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    src_pulse[0] |=> flag_q[0])
    else $error("event not recorded in flag");
  AST_PRIO_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    (prio_q[2:0] == `IEB_PRIO_OFF) |=> !irq_req_q[0])
    else $error("priority zero source passed");
endmodule // ieb_top

// >>> tb/ieb_cpu_model.sv
// far-side model of the priority logic: records requests it has seen
`timescale 1ns/1ns
module ieb_cpu_model
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // requests from the enable bank
  input  wire logic [47:0] irq_req_q,
  input  wire logic        irq_q,
  // bench control and view
  input  wire logic        clr,
  output logic [47:0]      req_seen_q,
  output logic             irq_seen_q
);
  logic [47:0] req_seen_d;
  logic        irq_seen_d;
  // sticky, so a one-cycle glitch between bench checks is not missed
  always_comb
  begin
    req_seen_d = clr ? '0 : (req_seen_q | irq_req_q);
    irq_seen_d = clr ? 1'b0 : (irq_seen_q | irq_q);
  end
  // registers only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_seen_q <= '0;
      irq_seen_q <= 1'b0;
    end
    else
    begin
      req_seen_q <= req_seen_d;
      irq_seen_q <= irq_seen_d;
    end
  end
endmodule // ieb_cpu_model

// >>> tb/interrupt_enable_bank_bench.sv
// self-checking bench for the interrupt enable bank
`timescale 1ns/1ns
module interrupt_enable_bank_bench;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        irq_q, clr, irq_seen;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [47:0] src_event, irq_req_q, req_seen, e;
  logic [15:0] msk [3];
  int          error_cnt, n_compared, r;
  // implemented enable positions of the three registers
  localparam logic [15:0] M1 = 16'hFEDF;
  localparam logic [15:0] M2 = 16'h3FE3;
  localparam logic [15:0] M3 = 16'h4066;
  ieb_top #(.NSRC(48)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .src_event(src_event), .irq_req_q(irq_req_q), .irq_q(irq_q));
  ieb_cpu_model cpu_u (.aclk(aclk), .aresetn(aresetn),
    .irq_req_q(irq_req_q), .irq_q(irq_q), .clr(clr),
    .req_seen_q(req_seen), .irq_seen_q(irq_seen));
  // 100 MHz clock
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // a wait that ran out is a mismatch and ends the run
  task automatic tmo();
    error_cnt++;
    $display("BAD timeout expected answer seen none");
    finish_test();
  endtask
  task automatic chk(input string nm, input logic [48:0] s,
                     input logic [48:0] x);
    n_compared++;
    if (s !== x)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask
  // axi4-lite write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    int  n;
    bit  pa, pw;
    pa = 1;
    pw = 1;
    n = 0;
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    wstrb   <= 4'hF;
    while (pa || pw)
    begin
      @(posedge aclk);
      if (pa && awready) begin pa = 0; awvalid <= 1'b0; end
      if (pw && wready) begin pw = 0; wvalid <= 1'b0; end
      if (++n > 50) tmo();
    end
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (++n > 100) tmo();
    end
    while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  // axi4-lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    n = 0;
    arvalid <= 1'b1;
    araddr  <= a;
    do
    begin
      @(posedge aclk);
      if (++n > 50) tmo();
    end
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (++n > 100) tmo();
    end
    while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // bounded wait for the summary and request outputs, then compare
  task automatic wt(input string nm, input logic [48:0] x);
    int n;
    for (n = 0; n < 10 && {irq_q, irq_req_q} !== x; n++)
      @(posedge aclk);
    chk(nm, {irq_q, irq_req_q}, x);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, clr} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    src_event = '0;
    msk = '{M1, M2, M3};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(8'h84, 32'h0, rsp);
    for (r = 0; r < 3; r++)
    begin
      rd(8'(4 * r), d, rsp);
      chk("enable reset", d, 49'h0);
      wr(8'(4 * r), 32'h0000FFFF, rsp);
      rd(8'(4 * r), d, rsp);
      chk("enables", d, msk[r]);
      chk("absent bits", d & ~{16'h0, msk[r]}, 49'h0);
    end
    // first register disabled, every source fires, external ones routed
    wr(8'h00, 32'h0, rsp);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    src_event <= '1;
    repeat (2) @(posedge aclk);
    src_event <= '0;
    wt("blocked requests", {1'b0, M3, M2, 16'h0});
    chk("blocked never seen", req_seen[15:0], 49'h0);
    rd(8'h0C, d, rsp);
    chk("flag kept", d[0], 49'h1);
    wr(8'h00, 32'h0000FFFF, rsp);
    wt("passed requests", {1'b0, M3, M2, M1});
    // priority codes zero, lowest and highest on source zero
    foreach (msk[i])
    begin
      d = (i == 0) ? 0 : (i == 1) ? 1 : 7;
      wr(8'h20, 32'h4920 | d, rsp);
      e = {M3, M2, M1};
      e[0] = (d != 0);
      wt("priority gate", {1'b0, e});
    end
    // fields one to four hold the level four written with each code
    rd(8'h20, d, rsp);
    chk("priority fields", d, 49'h4927);
    // interrupt: masked, unmasked, cleared
    rd(8'h80, d, rsp);
    chk("status", d[1:0], 49'h3);
    chk("masked irq", irq_seen, 49'h0);
    wr(8'h84, 32'h2, rsp);
    wt("unmasked irq", {1'b1, M3, M2, M1});
    for (r = 0; r < 6; r++)
      wr(8'(4 * r), 32'h0, rsp);
    wr(8'h80, 32'h3, rsp);
    rd(8'h80, d, rsp);
    chk("status cleared", d, 49'h0);
    wt("irq cleared", 49'h0);
    // unmapped place
    rd(8'h60, d, rsp);
    chk("unmapped data", d, 49'h0);
    chk("unmapped rresp", rsp, 49'h2);
    wr(8'h60, 32'hFFFF, rsp);
    chk("unmapped bresp", rsp, 49'h0);
    // software sets flags; absent places stay clear
    wr(8'h0C, 32'h0000FFFF, rsp);
    rd(8'h0C, d, rsp);
    chk("flag set by write", d, M1);
    // a reset in mid-run clears enables and flags again
    wr(8'h00, 32'h0000FFFF, rsp);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, d, rsp);
    chk("enable after reset", d, 49'h0);
    rd(8'h0C, d, rsp);
    chk("flags after reset", d, 49'h0);
    wt("requests after reset", 49'h0);
    finish_test();
  end
endmodule // interrupt_enable_bank_bench
